// *** inc/chan_bias_pkg.sv ***
// Purpose: constants shared by the channel and bias configuration bank
// Assumes: Avalon-MM slave, 32-bit data, one register per aligned word
// Notes:   printed offsets are register indices; byte address is four times
package chan_bias_pkg;

  localparam int unsigned NUM_CHAN = 8;

  // register indices as printed
  localparam logic [5:0] IDX_CHAN_FIRST = 6'h05;
  localparam logic [5:0] IDX_CHAN_LAST  = 6'h0c;
  localparam logic [5:0] IDX_BIAS_POS   = 6'h0d;
  localparam logic [5:0] IDX_BIAS_NEG   = 6'h0e;
  localparam logic [5:0] IDX_MISC       = 6'h1f;

  // channel and misc register field positions
  localparam int unsigned PD_BIT    = 7;
  localparam int unsigned GAIN_HI   = 6;
  localparam int unsigned GAIN_LO   = 4;
  localparam int unsigned RSVD_BIT  = 3;
  localparam int unsigned SRC_HI    = 2;
  localparam int unsigned SRC_LO    = 0;
  localparam int unsigned MEAS_BIT  = 0;
  localparam int unsigned VAR_HI    = 2;
  localparam int unsigned VAR_LO    = 1;

  // reset values
  localparam logic [7:0] CHAN_RESET = 8'h00;
  localparam logic [7:0] BIAS_RESET = 8'h00;
  localparam logic [7:0] MISC_RESET = 8'h00;

  // channel masks per variant
  localparam logic [7:0] MASK_FOUR  = 8'h0f;
  localparam logic [7:0] MASK_SIX   = 8'h3f;
  localparam logic [7:0] MASK_EIGHT = 8'hff;

  // variant codes held in the misc register
  localparam logic [1:0] VAR_EIGHT = 2'h0;
  localparam logic [1:0] VAR_SIX   = 2'h1;
  localparam logic [1:0] VAR_FOUR  = 2'h2;

  // source select codes
  localparam logic [2:0] SRC_NORMAL  = 3'h0;
  localparam logic [2:0] SRC_SHORT   = 3'h1;
  localparam logic [2:0] SRC_BIASMEA = 3'h2;
  localparam logic [2:0] SRC_SUPPLY  = 3'h3;
  localparam logic [2:0] SRC_TEMP    = 3'h4;
  localparam logic [2:0] SRC_TEST    = 3'h5;
  localparam logic [2:0] SRC_DRV_POS = 3'h6;
  localparam logic [2:0] SRC_DRV_NEG = 3'h7;

  // gain select codes
  localparam logic [2:0] GAIN_6  = 3'h0;
  localparam logic [2:0] GAIN_1  = 3'h1;
  localparam logic [2:0] GAIN_2  = 3'h2;
  localparam logic [2:0] GAIN_3  = 3'h3;
  localparam logic [2:0] GAIN_4  = 3'h4;
  localparam logic [2:0] GAIN_8  = 3'h5;
  localparam logic [2:0] GAIN_12 = 3'h6;

  // one-hot gain output bits
  localparam int unsigned GH_1  = 0;
  localparam int unsigned GH_2  = 1;
  localparam int unsigned GH_3  = 2;
  localparam int unsigned GH_4  = 3;
  localparam int unsigned GH_6  = 4;
  localparam int unsigned GH_8  = 5;
  localparam int unsigned GH_12 = 6;

  // bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;

endpackage

// *** hdl/chan_decode.sv ***
// Purpose: decode one channel setting byte into analog controls
// Assumes: pure combinational, registered by the caller
// Notes:   unused gain code 111 yields no gain bit set
`timescale 1ns/100ps
module chan_decode
  import chan_bias_pkg::*;
(
  // setting byte
  input  wire logic [7:0] setting,
  input  wire logic       meas_en,
  // decoded controls
  output logic            powerdown,
  output logic [6:0]      gain_onehot,
  output logic [7:0]      src_onehot,
  output logic            bias_in_route
);

  wire logic [2:0] gain_code;
  wire logic [2:0] src_code;

  assign gain_code = setting[GAIN_HI:GAIN_LO];
  assign src_code  = setting[SRC_HI:SRC_LO];
  assign powerdown = setting[PD_BIT];

  // gain map
  assign gain_onehot[GH_6]  = (gain_code == GAIN_6);
  assign gain_onehot[GH_1]  = (gain_code == GAIN_1);
  assign gain_onehot[GH_2]  = (gain_code == GAIN_2);
  assign gain_onehot[GH_3]  = (gain_code == GAIN_3);
  assign gain_onehot[GH_4]  = (gain_code == GAIN_4);
  assign gain_onehot[GH_8]  = (gain_code == GAIN_8);
  assign gain_onehot[GH_12] = (gain_code == GAIN_12);

  // source one-hot, bit index equals code
  assign src_onehot = 8'h01 << src_code;

  // bias input only closes with the enable
  assign bias_in_route = meas_en && (src_code == SRC_BIASMEA);

endmodule

// *** hdl/bias_mask.sv ***
// Purpose: gate bias derivation bits by the channel count of the variant
// Assumes: variant code stable while routing matters
// Notes:   only the drive path is masked; readback keeps what was written
`timescale 1ns/100ps
module bias_mask
  import chan_bias_pkg::*;
(
  input  wire logic [1:0] variant,
  input  wire logic [7:0] sel_pos,
  input  wire logic [7:0] sel_neg,
  output logic      [7:0] route_pos,
  output logic      [7:0] route_neg
);

  wire logic [7:0] mask;

  // four drops 7:4, six drops 7:6
  assign mask = (variant == VAR_FOUR) ? MASK_FOUR :
                (variant == VAR_SIX)  ? MASK_SIX  : MASK_EIGHT;
  assign route_pos = sel_pos & mask;
  assign route_neg = sel_neg & mask;

endmodule

// *** hdl/channel_and_bias_config_regs.sv ***
// Purpose: channel settings and bias derivation registers, Avalon-MM slave
// Assumes: one clock; master holds requests until waitrequest is low
// Notes:   every access answers one cycle after it is seen
//
// How it works
// - eight channel setting registers at indices 05h..0Ch, reset zero
// - bit 7 powers its channel down when one
// - bits 6:4 select gain 6,1,2,3,4,8,12 for codes 000..110
// - bits 2:0 select normal, shorted, supply, temperature, test source
// - source code 010 with measure enable reads the bias input
// - codes 110 and 111 make positive or negative electrode the driver
// - positive bias derivation register at 0Dh, bit n-1 routes channel n
// - negative bias derivation register at 0Eh, bit n-1 routes channel n
// - four-channel variant ignores bias bits 5:4
// - four and six channel variants ignore bias bits 7:6
// - measure enable routes bias input to every code 010 channel
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module channel_and_bias_config_regs
  import chan_bias_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // avalon-mm slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic [1:0]       AVS_RESPONSE,
  // channel controls, channel n at bit n-1, or in 7-bit gain and 8-bit source field n-1
  output logic [7:0]       CHAN_POWERDOWN,
  output logic [55:0]      AMP_GAIN_ONEHOT,
  output logic [63:0]      CHAN_SOURCE_ONEHOT,
  output logic [7:0]       BIAS_INPUT_ROUTE,
  // bias derivation controls
  output logic [7:0]       POS_INPUT_BIAS_ROUTE,
  output logic [7:0]       NEG_INPUT_BIAS_ROUTE
);

  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic       rst_meta_r;
  logic       rst_sync_r;
  wire  logic rst_n;

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  bus_state_e     state_r;
  bus_state_e     state_nxt;
  wire  logic       req;
  wire  logic [5:0] idx;
  wire  logic       aligned;
  wire  logic       hit_chan;
  wire  logic       hit_pos;
  wire  logic       hit_neg;
  wire  logic       hit_misc;
  wire  logic       mapped;
  wire  logic       wr_ok;
  wire  logic [2:0] chan_sel;

  assign req      = (AVS_READ || AVS_WRITE) && (state_r == BUS_IDLE);
  assign idx      = AVS_ADDRESS[7:2];
  assign aligned  = (AVS_ADDRESS[1:0] == 2'h0);
  // channel window is indices 05h..0Ch
  assign hit_chan = aligned && (idx >= IDX_CHAN_FIRST) && (idx <= IDX_CHAN_LAST);
  assign hit_pos  = aligned && (idx == IDX_BIAS_POS);
  assign hit_neg  = aligned && (idx == IDX_BIAS_NEG);
  assign hit_misc = aligned && (idx == IDX_MISC);
  assign mapped   = hit_chan || hit_pos || hit_neg || hit_misc;
  assign wr_ok    = req && AVS_WRITE && AVS_BYTEENABLE[0];
  assign chan_sel = 3'(idx - IDX_CHAN_FIRST);

  // two-state answer: accept, then drop waitrequest for one cycle
  always_comb
  begin
    case (state_r)
      BUS_IDLE: state_nxt = req ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  state_nxt = BUS_IDLE;
      default:  state_nxt = BUS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] chan_r [NUM_CHAN];
  logic [7:0] bias_pos_r;
  logic [7:0] bias_neg_r;
  logic [7:0] misc_r;

  // per-channel storage, bit 3 kept as plain storage
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++)
    begin : g_store
      always_ff @(posedge SYS_CLK or negedge rst_n)
      begin
        if (!rst_n)
          chan_r[gi] <= CHAN_RESET;
        else if (wr_ok && hit_chan && (chan_sel == 3'(gi)))
          chan_r[gi] <= AVS_WRITEDATA[7:0];
      end
    end
  endgenerate

  // bias and misc storage
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bias_pos_r <= BIAS_RESET;
      bias_neg_r <= BIAS_RESET;
      misc_r     <= MISC_RESET;
    end
    else
    begin
      if (wr_ok && hit_pos)
        bias_pos_r <= AVS_WRITEDATA[7:0];
      if (wr_ok && hit_neg)
        bias_neg_r <= AVS_WRITEDATA[7:0];
      if (wr_ok && hit_misc)
        misc_r <= AVS_WRITEDATA[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped or misaligned reads give zero with error response
  wire logic [7:0] chan_rd;
  wire logic [7:0] misc_rd;
  wire logic [7:0] rd_byte;

  assign chan_rd = chan_r[chan_sel];
  assign misc_rd = {5'h00, misc_r[VAR_HI:VAR_LO], misc_r[MEAS_BIT]};
  assign rd_byte = hit_chan ? chan_rd    :
                   hit_pos  ? bias_pos_r :
                   hit_neg  ? bias_neg_r :
                   hit_misc ? misc_rd    : 8'h00;

  // bus answer registers
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r         <= BUS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
      AVS_RESPONSE    <= 2'h0;
    end
    else
    begin
      state_r         <= state_nxt;
      AVS_WAITREQUEST <= !req;
      if (req)
      begin
        AVS_READDATA <= AVS_READ ? {24'h000000, rd_byte} : 32'h00000000;
        AVS_RESPONSE <= mapped ? 2'h0 : 2'h3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode and register analog controls
  wire logic       meas_en;
  wire logic [7:0] pd_w;
  wire logic [55:0] gain_w;
  wire logic [63:0] src_w;
  wire logic [7:0] bin_w;
  wire logic [7:0] rpos_w;
  wire logic [7:0] rneg_w;

  assign meas_en = misc_r[MEAS_BIT];

  generate
    for (gi = 0; gi < NUM_CHAN; gi++)
    begin : g_dec
      chan_decode u_dec (
        .setting       (chan_r[gi]),
        .meas_en       (meas_en),
        .powerdown     (pd_w[gi]),
        .gain_onehot   (gain_w[gi*7 +: 7]),
        .src_onehot    (src_w[gi*8 +: 8]),
        .bias_in_route (bin_w[gi])
      );
    end
  endgenerate

  // derivation mask by variant
  bias_mask u_mask (
    .variant   (misc_r[VAR_HI:VAR_LO]),
    .sel_pos   (bias_pos_r),
    .sel_neg   (bias_neg_r),
    .route_pos (rpos_w),
    .route_neg (rneg_w)
  );

  // outputs one cycle behind the registers, all from flops
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      CHAN_POWERDOWN       <= 8'h00;
      AMP_GAIN_ONEHOT      <= 56'h00000000000000;
      CHAN_SOURCE_ONEHOT   <= 64'h0000000000000000;
      BIAS_INPUT_ROUTE     <= 8'h00;
      POS_INPUT_BIAS_ROUTE <= 8'h00;
      NEG_INPUT_BIAS_ROUTE <= 8'h00;
    end
    else
    begin
      CHAN_POWERDOWN       <= pd_w;
      AMP_GAIN_ONEHOT      <= gain_w;
      CHAN_SOURCE_ONEHOT   <= src_w;
      BIAS_INPUT_ROUTE     <= bin_w;
      POS_INPUT_BIAS_ROUTE <= rpos_w;
      NEG_INPUT_BIAS_ROUTE <= rneg_w;
    end
  end

endmodule

// *** verification/cbc_asserts.sv ***
// Purpose: port-level checks for the channel and bias bank
// Assumes: one clock, bench requests only after internal reset release
// Notes:   routing checks tie outputs to each other and to bus writes
`timescale 1ns/100ps
module cbc_asserts
  import chan_bias_pkg::*;
(
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  // bus
  input wire logic [7:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [1:0]  AVS_RESPONSE,
  // controls
  input wire logic [7:0]  CHAN_POWERDOWN,
  input wire logic [63:0] CHAN_SOURCE_ONEHOT,
  input wire logic [7:0]  BIAS_INPUT_ROUTE,
  input wire logic [7:0]  POS_INPUT_BIAS_ROUTE
);
  logic [7:0] src_bias;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  // channels whose source field holds the bias measurement code
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      src_bias[i] = CHAN_SOURCE_ONEHOT[i*8+2];
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_wait_pulse;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("answer longer than one cycle");
  property p_answer;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_answer: assert property (p_answer)
    else $error("access not answered next cycle");
  property p_unmapped;
    AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == 8'h00
      |=> AVS_RESPONSE == 2'h3 && AVS_READDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not flagged");
  property p_src_count;
    $past(RESET_N, 5) |-> $countones(CHAN_SOURCE_ONEHOT) == 8;
  endproperty
  a_src_count: assert property (p_src_count)
    else $error("source select not one per channel");
  property p_bias_sub;
    (BIAS_INPUT_ROUTE & ~src_bias) == 8'h00;
  endproperty
  a_bias_sub: assert property (p_bias_sub)
    else $error("bias input on wrong source");
  property p_bias_all;
    |BIAS_INPUT_ROUTE |-> BIAS_INPUT_ROUTE == src_bias;
  endproperty
  a_bias_all: assert property (p_bias_all)
    else $error("bias input missing on a channel");
  property p_pd_cause;
    $changed(CHAN_POWERDOWN) |-> $past(AVS_WRITE && !AVS_WAITREQUEST);
  endproperty
  a_pd_cause: assert property (p_pd_cause)
    else $error("power-down moved without write");
  property p_pos_cause;
    $changed(POS_INPUT_BIAS_ROUTE) |-> $past(AVS_WRITE && !AVS_WAITREQUEST);
  endproperty
  a_pos_cause: assert property (p_pos_cause)
    else $error("bias route moved without write");
endmodule

// *** verification/tb.sv ***
// Purpose: self-checking bench for the channel and bias bank
// Assumes: each access answered within 50 cycles
// Notes:   expectations come from field codes, never from the design
`timescale 1ns/100ps
module tb;
  import chan_bias_pkg::*;
  // bus side
  logic        SYS_CLK;
  logic        RESET_N;
  logic [7:0]  AVS_ADDRESS;
  logic        AVS_READ;
  logic        AVS_WRITE;
  logic [31:0] AVS_WRITEDATA;
  logic [3:0]  AVS_BYTEENABLE;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic [1:0]  AVS_RESPONSE;
  // control side
  logic [7:0]  CHAN_POWERDOWN;
  logic [55:0] AMP_GAIN_ONEHOT;
  logic [63:0] CHAN_SOURCE_ONEHOT;
  logic [7:0]  BIAS_INPUT_ROUTE;
  logic [7:0]  POS_INPUT_BIAS_ROUTE;
  logic [7:0]  NEG_INPUT_BIAS_ROUTE;
  int          miscompares;
  int          compares;
  logic [31:0] rd;
  logic [1:0]  rsp;
  // gain code to one-hot position, and channel mask per variant code
  localparam logic [2:0] GPOS [7] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  localparam logic [7:0] MSK [4]  = '{MASK_EIGHT, MASK_SIX, MASK_FOUR, MASK_EIGHT};

  channel_and_bias_config_regs u_dut (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE),
    .CHAN_POWERDOWN(CHAN_POWERDOWN), .AMP_GAIN_ONEHOT(AMP_GAIN_ONEHOT),
    .CHAN_SOURCE_ONEHOT(CHAN_SOURCE_ONEHOT), .BIAS_INPUT_ROUTE(BIAS_INPUT_ROUTE),
    .POS_INPUT_BIAS_ROUTE(POS_INPUT_BIAS_ROUTE),
    .NEG_INPUT_BIAS_ROUTE(NEG_INPUT_BIAS_ROUTE));

  // free-running 250 MHz clock
  initial
  begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  // one access; request held until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge SYS_CLK);
    AVS_ADDRESS   <= a;
    AVS_WRITE     <= w;
    AVS_READ      <= ~w;
    AVS_WRITEDATA <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end
    while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    if (n >= 50)
      miscompares++;
    rd  = AVS_READDATA;
    rsp = AVS_RESPONSE;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(n, rd, {24'h0, e});
  endtask

  task automatic t_reset;
    for (int i = 0; i < 10; i++)
      rdchk("reset", 8'h14 + 8'(4*i), 8'h00);
    chk("src", CHAN_SOURCE_ONEHOT, 64'h0101010101010101);
    acc(1'b0, 8'h00, 8'h00);
    chk("resp", rsp, 2'h3);
  endtask

  // every gain and source code, reserved bit set on the first channel
  task automatic t_chan;
    logic [7:0] v;
    logic [6:0] g;
    for (int c = 0; c < 8; c++)
    begin
      // only channel 2 powers down, and it carries the shorted code
      v = {c == 1, c[2:0], c == 0, c[2:0]};
      acc(1'b1, 8'h14 + 8'(4*c), v);
      rdchk("chan", 8'h14 + 8'(4*c), v);
      g = (c == 7) ? 7'h00 : 7'h01 << GPOS[c];
      chk("pd", CHAN_POWERDOWN[c], c == 1);
      chk("gain", AMP_GAIN_ONEHOT[c*7+:7], g);
      chk("src", CHAN_SOURCE_ONEHOT[c*8+:8], 8'h01 << c);
    end
  endtask

  // masked write leaves the register alone; misaligned read gives zero with error response
  task automatic t_edge;
    AVS_BYTEENABLE <= 4'he;
    acc(1'b1, 8'h14, 8'h77);
    chk("be_rsp", rsp, 2'h0);
    AVS_BYTEENABLE <= 4'hf;
    rdchk("be_keep", 8'h14, 8'h08);
    acc(1'b0, 8'h15, 8'h00);
    chk("mis_rsp", rsp, 2'h3);
    chk("mis_rd", rd, 32'h00000000);
  endtask

  // third channel holds the bias measurement code
  task automatic t_meas;
    acc(1'b1, 8'h7c, 8'h01);
    @(posedge SYS_CLK);
    chk("meas", BIAS_INPUT_ROUTE, 8'h04);
    acc(1'b1, 8'h7c, 8'h00);
    @(posedge SYS_CLK);
    chk("meas", BIAS_INPUT_ROUTE, 8'h00);
  endtask

  task automatic t_bias;
    acc(1'b1, 8'h34, 8'hff);
    acc(1'b1, 8'h38, 8'ha5);
    for (int v = 0; v < 4; v++)
    begin
      acc(1'b1, 8'h7c, {5'h0, 2'(v), 1'b0});
      @(posedge SYS_CLK);
      chk("pos", POS_INPUT_BIAS_ROUTE, MSK[v]);
      chk("neg", NEG_INPUT_BIAS_ROUTE, 8'ha5 & MSK[v]);
      rdchk("neg", 8'h38, 8'ha5);
    end
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // main sequence
  initial
  begin
    RESET_N        = 1'b0;
    AVS_ADDRESS    = 8'h00;
    AVS_READ       = 1'b0;
    AVS_WRITE      = 1'b0;
    AVS_WRITEDATA  = 32'h0;
    AVS_BYTEENABLE = 4'hf;
    miscompares    = 0;
    compares       = 0;
    repeat (4) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    t_reset();
    t_chan();
    t_edge();
    t_meas();
    t_bias();
    end_of_test();
  end

  // watchdog, far beyond the roughly 140 cycles needed
  initial
  begin
    #40000;
    miscompares++;
    end_of_test();
  end
endmodule

bind channel_and_bias_config_regs cbc_asserts u_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE),
  .CHAN_POWERDOWN(CHAN_POWERDOWN), .CHAN_SOURCE_ONEHOT(CHAN_SOURCE_ONEHOT),
  .BIAS_INPUT_ROUTE(BIAS_INPUT_ROUTE), .POS_INPUT_BIAS_ROUTE(POS_INPUT_BIAS_ROUTE));
